/* File: rtl/rpd_pkg.sv */
// rotor position detector: shared constants, register map and types
// assumes a byte wide register port and one 200 MHz clock
package rpd_pkg;

   // ************************************************************
   // clock and register map
   // ************************************************************
   localparam int CLOCK_MHZ = 200; // system clock rate
   localparam int ADDR_W = 16; // register address width
   localparam logic [15:0] ADDR_CONTROL = 16'h1fa0; // detection_control
   localparam logic [15:0] ADDR_CONFIG = 16'h1fa1; // sampling_config
   localparam logic [15:0] ADDR_STATUS = 16'h1fa2; // position_detect_status
   localparam logic [7:0] RESET_CONTROL = 8'h00; // control reset value
   localparam logic [7:0] RESET_CONFIG = 8'h00; // config reset value

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int CTL_SOFT_STOP = 7; // soft_stop_bit, write only
   localparam int CTL_SOFT_START = 6; // soft_start_bit, write only
   localparam int CTL_TIMER_STOP = 5; // timer_stop_enable
   localparam int CTL_TIMER_START = 4; // timer_start_enable
   localparam int CTL_SINGLE = 3; // single_input_select
   localparam int CTL_RECOUNT = 2; // per_pulse_recount
   localparam int CTL_CHANGE = 1; // change_detect_select
   localparam int CTL_ENABLE = 0; // detection_enable
   localparam int CFG_PERIOD_LO = 6; // sample_period_select
   localparam int CFG_MODE_LO = 4; // sample_gating_mode
   localparam int CFG_COUNT_LO = 0; // consecutive_hit_count
   localparam int STS_EDGE_LO = 4; // pwm_edge_result
   localparam int STS_ACTIVE = 3; // sampling_active_flag
   localparam int STS_SNAP_LO = 0; // start_level_snapshot

   // ************************************************************
   // encodings and timing
   // ************************************************************
   localparam logic [1:0] MODE_PWM_ON = 2'h0; // sample while pwm on
   localparam logic [1:0] MODE_ALWAYS = 2'h1; // sample continuously
   localparam logic [1:0] MODE_LOWER = 2'h2; // sample while lower phase conducts
   localparam logic [1:0] EDGE_CURRENT = 2'h0; // detected in current pulse
   localparam logic [1:0] EDGE_PWM_OFF = 2'h1; // detected while pwm off
   localparam logic [1:0] EDGE_PRECEDING = 2'h3; // detected in preceding pulse
   localparam logic [4:0] DIV_LAST_4 = 5'h03; // period clock divide by 4
   localparam logic [4:0] DIV_LAST_8 = 5'h07; // divide by 8
   localparam logic [4:0] DIV_LAST_16 = 5'h0f; // divide by 16
   localparam logic [4:0] DIV_LAST_32 = 5'h1f; // divide by 32
   localparam logic [3:0] HITS_MIN = 4'h1; // a count of 0 acts as 1

   // three phase levels, bit 2 w, bit 1 v, bit 0 u
   typedef struct packed {
      logic w;
      logic v;
      logic u;
   } rpd_phase_t;

   // register port request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rpd_bus_t;

endpackage : rpd_pkg

/* File: rtl/rpd_detector.sv */
// rotor position detector: samples the u, v, w position inputs, compares
// them with an expected pattern or with the levels caught at start, and
// flags a detection after a run of consecutive hits.
// assumes pins are asynchronous, pwm and timer triggers are on this clock.
//
// Decided for this implementation: the address-and-strobe port.
module rpd_detector
   import rpd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // register port
   input wire rpd_pkg::rpd_bus_t bus,
   output logic [7:0] rd_data,
   // position pins and their direction
   input wire rpd_pkg::rpd_phase_t phase_pins,
   input wire rpd_pkg::rpd_phase_t pin_is_output,
   // expected pattern from the pattern output register
   input wire rpd_pkg::rpd_phase_t expected_pattern,
   // pwm and lower phase conduction state
   input wire logic pwm_active_period,
   input wire rpd_pkg::rpd_phase_t lower_conducting,
   // timer triggers, one cycle pulses
   input wire logic timer2_trigger,
   input wire logic timer3_trigger,
   // detection results
   output logic position_detected,
   output logic position_irq,
   output logic sampling_active_out
);
   import rpd_pkg::*;

   // ************************************************************
   // registers and state
   // ************************************************************
   logic [5:0] control; // stored control bits 5..0
   logic [7:0] sampling_config; // period, mode, count
   logic soft_start_pulse; // one cycle start from a write
   logic soft_stop_pulse; // one cycle stop from a write
   logic sampling_active_flag; // sampling in progress
   rpd_phase_t start_level_snapshot; // levels at sampling start
   logic [1:0] pwm_edge_result; // edge field of status
   logic [4:0] div_count; // sampling period divider
   logic [3:0] hit_count; // consecutive hits so far
   logic armed; // ordinary mode saw a mismatch
   logic rose_in_run; // pwm turned on during hit run
   rpd_phase_t held; // last sampled level per phase
   logic pwm_q; // pwm one cycle ago
   rpd_phase_t sync1; // pin synchroniser stage one
   rpd_phase_t sync2; // stage two
   rpd_phase_t sync3; // stage three
   rpd_phase_t pins_stable; // filtered pin levels

   // ************************************************************
   // combinational helpers
   // ************************************************************
   logic write_control; // write to control this cycle
   logic write_config; // write to config this cycle
   logic [4:0] div_last; // divider end count
   logic tick; // sampling period tick
   logic [1:0] gate_mode; // selected gate mode
   rpd_phase_t gate; // per phase sampling gate
   logic sample_now; // a sample is taken this cycle
   rpd_phase_t presented; // masked inputs to the comparator
   rpd_phase_t next_held; // held levels after this sample
   rpd_phase_t reference; // pattern to compare against
   logic [2:0] cmp_mask; // which phases take part
   logic equal; // masked inputs equal reference
   logic hit; // this sample counts as a hit
   logic [3:0] target; // hits needed for detection
   logic detect; // detection fires this cycle
   logic start_req; // any start request
   logic stop_req; // any stop request
   logic pwm_fall; // pwm turned off
   logic pwm_rise; // pwm turned on
   logic recount_clear; // hit count cleared by pwm off

   assign write_control = bus.wr && (bus.addr == ADDR_CONTROL);
   assign write_config = bus.wr && (bus.addr == ADDR_CONFIG);
   assign pwm_fall = pwm_q && !pwm_active_period;
   assign pwm_rise = !pwm_q && pwm_active_period;
   assign gate_mode = sampling_config[CFG_MODE_LO +: 2];
   // output pins read as zero so unused phases drop out
   assign presented = pins_stable & ~pin_is_output;

   // ************************************************************
   // pin synchroniser: a change counts once stages two and three agree
   // ************************************************************
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         sync3 <= 3'h0;
      end
      else
      begin
         sync1 <= phase_pins;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // filtered level, updated per phase when the last two stages agree
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         pins_stable <= 3'h0;
      end
      else
      begin
         pins_stable <= (sync2 & sync3) | (pins_stable & (sync2 ^ sync3));
      end
   end

   // pwm history for edge detection
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         pwm_q <= 1'b0;
      end
      else
      begin
         pwm_q <= pwm_active_period;
      end
   end

   // ************************************************************
   // sampling period divider
   // ************************************************************
   always_comb
   begin
      // period select picks divide by 4, 8, 16 or 32
      case (sampling_config[CFG_PERIOD_LO +: 2])
         2'h0: div_last = DIV_LAST_4;
         2'h1: div_last = DIV_LAST_8;
         2'h2: div_last = DIV_LAST_16;
         default: div_last = DIV_LAST_32;
      endcase
   end

   assign tick = (div_count == div_last);

   // free running while sampling, held at zero while idle
   always_ff @(posedge clock)
   begin
      if (sys_rst || !sampling_active_flag || tick)
      begin
         div_count <= 5'h00;
      end
      else
      begin
         div_count <= div_count + 5'h01;
      end
   end

   // ************************************************************
   // sampling gate and held levels
   // ************************************************************
   always_comb
   begin
      // gate mode 00 pwm on, 01 always, 10 lower phase, 11 none
      case (gate_mode)
         MODE_PWM_ON: gate = {3{pwm_active_period}};
         MODE_ALWAYS: gate = 3'h7;
         MODE_LOWER: gate = lower_conducting;
         default: gate = 3'h0;
      endcase
   end

   assign sample_now = sampling_active_flag && tick && (gate != 3'h0);
   // idle phases keep their last result while others sample
   assign next_held = (presented & gate) | (held & ~gate);

   always_ff @(posedge clock)
   begin
      if (sys_rst || start_req)
      begin
         held <= presented;
      end
      else if (sample_now)
      begin
         held <= next_held;
      end
   end

   // ************************************************************
   // comparison and hit counting
   // ************************************************************
   // unmatch mode compares with start levels, ordinary with pattern
   assign reference = control[CTL_CHANGE] ? start_level_snapshot : expected_pattern;
   // single input select leaves only phase u in play
   assign cmp_mask = control[CTL_SINGLE] ? 3'h1 : 3'h7;
   assign equal = ((next_held ^ reference) & cmp_mask) == 3'h0;
   // ordinary mode needs a mismatch first; unmatch mode counts differences
   assign hit = control[CTL_CHANGE] ? !equal : (equal && armed);
   // a programmed zero behaves as one
   assign target = (sampling_config[CFG_COUNT_LO +: 4] == 4'h0) ? HITS_MIN
                   : sampling_config[CFG_COUNT_LO +: 4];
   assign detect = sample_now && hit && ((hit_count + 4'h1) >= target);
   assign recount_clear = (gate_mode == MODE_PWM_ON) && control[CTL_RECOUNT]
                          && pwm_fall;

   // consecutive hit counter
   always_ff @(posedge clock)
   begin
      if (sys_rst || !sampling_active_flag || detect || recount_clear)
      begin
         hit_count <= 4'h0;
      end
      else if (sample_now)
      begin
         // a miss breaks the run
         hit_count <= hit ? hit_count + 4'h1 : 4'h0;
      end
   end

   // ordinary mode arms once inputs differ from the pattern
   always_ff @(posedge clock)
   begin
      if (sys_rst || start_req || detect)
      begin
         armed <= 1'b0;
      end
      else if (sample_now && !equal)
      begin
         armed <= 1'b1;
      end
   end

   // ************************************************************
   // start, stop and sampling state
   // ************************************************************
   assign start_req = control[CTL_ENABLE]
                      && (soft_start_pulse
                          || (timer2_trigger && control[CTL_TIMER_START]));
   assign stop_req = soft_stop_pulse
                     || (timer3_trigger && control[CTL_TIMER_STOP]);

   // detection and stop both end sampling; detection is still reported
   always_ff @(posedge clock)
   begin
      if (sys_rst || !control[CTL_ENABLE])
      begin
         sampling_active_flag <= 1'b0;
      end
      else if (detect || stop_req)
      begin
         sampling_active_flag <= 1'b0;
      end
      else if (start_req)
      begin
         sampling_active_flag <= 1'b1;
      end
   end

   // levels caught at sampling start in unmatch mode
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         start_level_snapshot <= 3'h0;
      end
      else if (start_req && control[CTL_CHANGE])
      begin
         start_level_snapshot <= presented;
      end
   end

   // ************************************************************
   // pwm edge result
   // ************************************************************
   // notes whether pwm turned on since the hit run began
   always_ff @(posedge clock)
   begin
      if (sys_rst || start_req || (sample_now && !hit))
      begin
         rose_in_run <= 1'b0;
      end
      else if (pwm_rise && hit_count != 4'h0)
      begin
         rose_in_run <= 1'b1;
      end
   end

   // bit 5 rising side, bit 4 falling side of the pulse
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         pwm_edge_result <= EDGE_CURRENT;
      end
      else if (detect)
      begin
         if (!pwm_active_period)
         begin
            pwm_edge_result <= EDGE_PWM_OFF;
         end
         else if (rose_in_run)
         begin
            pwm_edge_result <= EDGE_PRECEDING;
         end
         else
         begin
            pwm_edge_result <= EDGE_CURRENT;
         end
      end
   end

   // detection outputs, one cycle pulses
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         position_detected <= 1'b0;
         position_irq <= 1'b0;
      end
      else
      begin
         position_detected <= detect;
         position_irq <= detect;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         sampling_active_out <= 1'b0;
      end
      else
      begin
         sampling_active_out <= sampling_active_flag;
      end
   end

   // ************************************************************
   // register writes
   // ************************************************************
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         control <= RESET_CONTROL[5:0];
         sampling_config <= RESET_CONFIG;
      end
      else
      begin
         if (write_control)
         begin
            control <= bus.wdata[5:0];
         end
         if (write_config)
         begin
            sampling_config <= bus.wdata;
         end
      end
   end

   // start and stop last one cycle, never stored
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         soft_start_pulse <= 1'b0;
         soft_stop_pulse <= 1'b0;
      end
      else
      begin
         soft_start_pulse <= write_control && bus.wdata[CTL_SOFT_START];
         soft_stop_pulse <= write_control && bus.wdata[CTL_SOFT_STOP];
      end
   end

   // ************************************************************
   // register reads: data stand one cycle after the strobe
   // ************************************************************
   always_ff @(posedge clock)
   begin
      if (sys_rst || !bus.rd)
      begin
         rd_data <= 8'h00;
      end
      else if (bus.addr == ADDR_CONTROL)
      begin
         // write only bits 7 and 6 read as zero
         rd_data <= {2'h0, control};
      end
      else if (bus.addr == ADDR_CONFIG)
      begin
         rd_data <= sampling_config;
      end
      else if (bus.addr == ADDR_STATUS)
      begin
         rd_data <= {2'h0, pwm_edge_result, sampling_active_flag,
                     start_level_snapshot};
      end
      else
      begin
         // unmapped addresses read zero
         rd_data <= 8'h00;
      end
   end

endmodule : rpd_detector

/* File: tb/rpd_pin_model.sv */
// position pin partner: drives the u, v, w pins from a requested pattern
// assumes the bench changes target and slow right after a rising edge
module rpd_pin_model
   import rpd_pkg::*;
(
   // clock
   input wire logic clock,
   // requested levels and response speed
   input wire rpd_pkg::rpd_phase_t target,
   input wire logic slow,
   // pins towards the detector
   output rpd_pkg::rpd_phase_t phase_pins
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************************
   // comparator settling
   // ************************************************************
   rpd_phase_t d1, d2, d3; // settling pipeline
   // history of the requested levels
   always_ff @(posedge clock)
   begin
      d1 <= target;
      d2 <= d1;
      d3 <= d2;
   end
   // slow comparator chatters back to the old level for one cycle
   always_comb
   begin
      if (!slow)
         phase_pins = target;
      else if (d1 != d2)
         phase_pins = d1;
      else if (d2 != d3)
         phase_pins = d3;
      else
         phase_pins = d2;
   end
endmodule : rpd_pin_model

/* File: tb/rpd_detector_sva.sv */
// rotor position detector checker: port level timing properties
// assumes it is bound to rpd_detector and sees only its ports
module rpd_detector_sva
   import rpd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // register port
   input wire rpd_pkg::rpd_bus_t bus,
   input wire logic [7:0] rd_data,
   // pins, gating and triggers
   input wire rpd_pkg::rpd_phase_t phase_pins,
   input wire rpd_pkg::rpd_phase_t pin_is_output,
   input wire rpd_pkg::rpd_phase_t expected_pattern,
   input wire logic pwm_active_period,
   input wire rpd_pkg::rpd_phase_t lower_conducting,
   input wire logic timer2_trigger,
   input wire logic timer3_trigger,
   // results
   input wire logic position_detected,
   input wire logic position_irq,
   input wire logic sampling_active_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************************
   // shadow of the stored control bits
   // ************************************************************
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic [5:0] ctl; // stored control bits
   logic wr_ctl; // write to the control register
   assign wr_ctl = bus.wr && bus.addr == ADDR_CONTROL;
   // follow every control write
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         ctl <= 6'h00;
      else if (wr_ctl)
         ctl <= bus.wdata[5:0];
   end
   // ************************************************************
   // properties
   // ************************************************************
   property p_irq_pair;
      position_irq == position_detected;
   endproperty
   a_irq_pair: assert property (p_irq_pair) else $error("irq differs from detect");
   property p_det_stops;
      position_detected |-> ##1 !sampling_active_out;
   endproperty
   a_det_stops: assert property (p_det_stops) else $error("sampling left on");
   property p_sts_read;
      $past(bus.rd) && $past(bus.addr) == ADDR_STATUS
         |-> rd_data[3] == sampling_active_out && rd_data[7:6] == 2'h0;
   endproperty
   a_sts_read: assert property (p_sts_read) else $error("status bit 3 wrong");
   property p_ctl_wo;
      $past(bus.rd) && $past(bus.addr) == ADDR_CONTROL |-> rd_data[7:6] == 2'h0;
   endproperty
   a_ctl_wo: assert property (p_ctl_wo) else $error("start or stop bit read");
   property p_det_active;
      position_detected |-> $past(sampling_active_out) || $past(sampling_active_out, 2);
   endproperty
   a_det_active: assert property (p_det_active) else $error("detect while idle");
   property p_soft_start;
      wr_ctl && bus.wdata[6] && bus.wdata[0] && !bus.wdata[7] |-> ##3 sampling_active_out;
   endproperty
   a_soft_start: assert property (p_soft_start) else $error("soft start lost");
   property p_tmr_start;
      timer2_trigger && ctl[4] && ctl[0] && !sampling_active_out |-> ##2 sampling_active_out;
   endproperty
   a_tmr_start: assert property (p_tmr_start) else $error("timer start lost");
   property p_disable;
      wr_ctl && !bus.wdata[0] |-> ##3 !sampling_active_out;
   endproperty
   a_disable: assert property (p_disable) else $error("runs while disabled");
   property p_tmr_stop;
      timer3_trigger && ctl[5] |-> ##[1:3] !sampling_active_out;
   endproperty
   a_tmr_stop: assert property (p_tmr_stop) else $error("timer stop lost");
   property p_soft_stop;
      wr_ctl && bus.wdata[7] |-> ##[1:4] !sampling_active_out;
   endproperty
   a_soft_stop: assert property (p_soft_stop) else $error("soft stop lost");
   c_detect: cover property (position_detected);
   c_tmr_stop: cover property (timer3_trigger && ctl[5] && sampling_active_out);
   c_start: cover property (wr_ctl && bus.wdata[6]);
endmodule : rpd_detector_sva

bind rpd_detector rpd_detector_sva u_sva (.clock(clock), .sys_rst(sys_rst), .bus(bus),
   .rd_data(rd_data), .phase_pins(phase_pins), .pin_is_output(pin_is_output),
   .expected_pattern(expected_pattern), .pwm_active_period(pwm_active_period),
   .lower_conducting(lower_conducting), .timer2_trigger(timer2_trigger),
   .timer3_trigger(timer3_trigger), .position_detected(position_detected),
   .position_irq(position_irq), .sampling_active_out(sampling_active_out));

/* File: tb/rpd_detector_tb_top.sv */
// rotor position detector bench: register port master, pin partner, checks
// assumes a 200 MHz clock and the checker bound to the detector
module rpd_detector_tb_top
   import rpd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************************
   // signals
   // ************************************************************
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   rpd_bus_t bus = '0;
   logic [7:0] rd_data;
   rpd_phase_t phase_pins, target = '0, pin_is_output = '0;
   rpd_phase_t expected_pattern = '0, lower_conducting = '0;
   logic pwm_active_period = 1'b0, pwm_run = 1'b0, slow = 1'b0;
   logic timer2_trigger = 1'b0, timer3_trigger = 1'b0, rd_pend = 1'b0;
   logic position_detected, position_irq, sampling_active_out;
   int err_count = 0, n_compared = 0, cyc = 0, pwm_cnt = 0;
   logic [15:0] expq[$]; // expected reads, mask above value
   logic [15:0] mon_e; // note taken by the monitor
   always #2.5 clock = ~clock;
   rpd_detector uut (.clock(clock), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data),
      .phase_pins(phase_pins), .pin_is_output(pin_is_output),
      .expected_pattern(expected_pattern), .pwm_active_period(pwm_active_period),
      .lower_conducting(lower_conducting), .timer2_trigger(timer2_trigger),
      .timer3_trigger(timer3_trigger), .position_detected(position_detected),
      .position_irq(position_irq), .sampling_active_out(sampling_active_out));
   rpd_pin_model u_pins (.clock(clock), .target(target), .slow(slow),
      .phase_pins(phase_pins));
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      bus <= '0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] v);
      @(posedge clock);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      expq.push_back({m, v});
      @(posedge clock);
      bus <= '0;
   endtask : rd
   task automatic pulse(input logic stop);
      @(posedge clock);
      timer2_trigger <= !stop;
      timer3_trigger <= stop;
      @(posedge clock);
      timer2_trigger <= 1'b0;
      timer3_trigger <= 1'b0;
   endtask : pulse
   // one start, a pin change, then a bounded wait for the detection
   task automatic run(input logic [7:0] cfg, input logic [7:0] ctl, input rpd_phase_t xp,
      input rpd_phase_t po, input rpd_phase_t lc, input rpd_phase_t p0,
      input rpd_phase_t p1, input logic det, input int slack);
      int n;
      int p;
      int k;
      logic got;
      logic always_md;
      p = 4 << cfg[7:6];
      n = (cfg[3:0] == 4'h0) ? 1 : int'(cfg[3:0]);
      always_md = cfg[5:4] == MODE_ALWAYS;
      got = 1'b0;
      k = 0;
      @(posedge clock);
      expected_pattern <= xp;
      pin_is_output <= po;
      lower_conducting <= lc;
      target <= p0;
      slow <= 1'($urandom);
      repeat (8) @(posedge clock);
      wr(ADDR_CONFIG, cfg);
      wr(ADDR_CONTROL, ctl);
      if (!ctl[6])
         pulse(1'b0);
      rd(ADDR_STATUS, ctl[1] ? 8'h0f : 8'h08, {5'h01, ctl[1] ? p0 : 3'h0});
      @(posedge clock);
      target <= p1;
      while (k < (n + 1) * p + 12 + slack && !got)
      begin
         @(posedge clock);
         k++;
         got = position_detected;
      end
      check("detected", {7'h0, got}, {7'h0, det});
      check("irq", {7'h0, position_irq}, {7'h0, got});
      if (det)
         check("early", {7'h0, k >= (n - 1) * p}, 8'h01);
      // pwm off at detection gives 01; a run spanning a pwm rise gives 11
      rd(ADDR_STATUS, det ? 8'h38 : 8'h08,
         det ? (pwm_run ? 8'h30 : 8'h10) : 8'h08);
      wr(ADDR_CONTROL, 8'h80);
      rd(ADDR_STATUS, 8'h08, 8'h00);
      wr(ADDR_CONTROL, 8'h00);
      $display("test done cfg %h ctl %h", cfg, ctl);
   endtask : run
   // ************************************************************
   // monitor, pwm source and timeout
   // ************************************************************
   // compare each read answer with the oldest note
   always @(posedge clock)
   begin
      rd_pend <= bus.rd;
      if (rd_pend)
      begin
         mon_e = expq.pop_front();
         check("rd_data", rd_data & mon_e[15:8], mon_e[7:0]);
      end
   end
   // pwm on for 40 cycles of every 60
   always @(posedge clock)
   begin
      pwm_cnt <= (pwm_cnt == 59) ? 0 : pwm_cnt + 1;
      pwm_active_period <= pwm_run && pwm_cnt < 40;
   end
   // cut a hang short
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_count++;
         final_report();
      end
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      rpd_phase_t r;
      logic [7:0] c;
      logic [3:0] cnts[4] = '{4'h0, 4'h1, 4'h5, 4'hf};
      void'($urandom(48036));
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      rd(ADDR_CONTROL, 8'hff, RESET_CONTROL);
      rd(ADDR_CONFIG, 8'hff, RESET_CONFIG);
      wr(ADDR_STATUS, 8'hff);
      rd(ADDR_STATUS, 8'hff, 8'h00);
      rd(16'h1fa3, 8'hff, 8'h00);
      c = 8'($urandom);
      wr(ADDR_CONFIG, c);
      rd(ADDR_CONFIG, 8'hff, c);
      wr(ADDR_CONTROL, 8'hfe);
      rd(ADDR_CONTROL, 8'hff, 8'h3e);
      wr(ADDR_CONTROL, 8'h00);
      $display("test done registers");
      for (int d = 0; d < 4; d++)
      begin
         r = 3'($urandom);
         run({2'(d), MODE_ALWAYS, cnts[d]}, 8'h43, 3'h0, 3'h0, 3'h0, r, ~r, 1'b1, 8);
      end
      r = 3'($urandom);
      run(8'h11, 8'h33, 3'h0, 3'h0, 3'h0, r, ~r, 1'b1, 8);
      run(8'h53, 8'h43, 3'h0, 3'h0, 3'h0, r, r, 1'b0, 0);
      run(8'h12, 8'h49, 3'h1, 3'h0, 3'h0, 3'h6, 3'h7, 1'b1, 8);
      run(8'h11, 8'h41, 3'h1, 3'h6, 3'h0, 3'h6, 3'h7, 1'b1, 8);
      run(8'h11, 8'h41, 3'h5, 3'h0, 3'h0, 3'h5, 3'h5, 1'b0, 0);
      run({2'h0, MODE_LOWER, 4'h2}, 8'h43, 3'h0, 3'h0, 3'h7, r, ~r, 1'b1, 8);
      pwm_run <= 1'b1;
      run(8'h0f, 8'h47, 3'h0, 3'h0, 3'h0, r, ~r, 1'b0, 200);
      run(8'h0f, 8'h43, 3'h0, 3'h0, 3'h0, ~r, r, 1'b1, 200);
      pwm_run <= 1'b0;
      wr(ADDR_CONFIG, 8'h11);
      wr(ADDR_CONTROL, 8'h33);
      pulse(1'b0);
      rd(ADDR_STATUS, 8'h08, 8'h08);
      pulse(1'b1);
      rd(ADDR_STATUS, 8'h08, 8'h00);
      wr(ADDR_CONTROL, 8'h30);
      pulse(1'b0);
      rd(ADDR_STATUS, 8'h08, 8'h00);
      wr(ADDR_CONTROL, 8'h00);
      $display("test done timer triggers");
      repeat (4) @(posedge clock);
      final_report();
   end
endmodule : rpd_detector_tb_top
